/* common/lin_pkg.sv */
// Constants and types for the tare, access code and lineariser control
package lin_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SEL = 8'h04;
  localparam logic [7:0] A_DVAL = 8'h08;
  localparam logic [7:0] A_CODE = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_DISP = 8'h14;
  // Control register bit positions
  localparam int C_LIN = 0;
  localparam int C_INS = 8;
  localparam int C_REMOVE = 9;
  localparam int C_CAP = 10;
  localparam int C_RCONF = 11;
  localparam int C_RTAB = 12;
  localparam int C_CAL = 13;
  localparam int C_CLRF = 14;
  // Status register bit positions
  localparam int S_FAIL = 0;
  localparam int S_TARE = 1;
  localparam int S_TEN = 2;
  localparam int S_LDEL = 3;
  localparam int S_MODE = 4;
  localparam int S_SEL = 8;
  localparam int S_CNT = 16;
  // Table geometry and currents in microamps
  localparam int NPTS = 17;
  localparam logic [4:0] MAX_PTS = 5'h11;
  localparam logic [4:0] MIN_PTS = 5'h02;
  localparam logic [15:0] CUR_MIN_UA = 16'h0ed8;
  localparam logic [15:0] CUR_MAX_UA = 16'h5208;
  localparam logic [15:0] LOW_LOOP_UA = 16'h0708;
  localparam logic [15:0] DEF_C0 = 16'h0fa0;
  localparam logic [15:0] DEF_C1 = 16'h4e20;
  localparam logic [15:0] DEF_D0 = 16'h0000;
  localparam logic [15:0] DEF_D1 = 16'h03e8;
  localparam logic [15:0] CODE_DEF = 16'h0000;
  // Display and bargraph limits in display counts
  localparam logic signed [35:0] DISP_MAX = 36'sh0_0000_270f;
  localparam logic signed [35:0] DISP_MIN = -36'sh0_0000_03e7;
  localparam logic signed [35:0] BAR_LO = 36'sh0_0000_0000;
  localparam logic signed [35:0] BAR_HI = 36'sh0_0000_03e8;
  // Tare hold time
  localparam int TARE_HOLD_MS = 32'h0000_0bb8;
  localparam int CLK_KHZ = 32'h0001_e848;
  localparam int TARE_HOLD_CYC = TARE_HOLD_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    ST_DISPLAY = 2'b00,
    ST_CODE = 2'b01,
    ST_MENU = 2'b10,
    ST_TARE_ITEM = 2'b11
  } mode_t;

  typedef struct packed {
    logic enter;
    logic up;
    logic down;
    logic prog;
  } btn_t;

  typedef struct packed {
    logic signed [15:0] value;
    logic signed [15:0] bar;
    logic dp_flash;
    logic tare_ann;
    logic low_loop_warning;
    logic arrow_lo;
    logic arrow_hi;
  } disp_t;

  typedef struct packed {
    mode_t mode;
    logic [1:0] dig;
    logic [15:0] entry;
    logic [15:0] code;
    logic [15:0] code_pend;
    logic tare_setting;
    logic tare_on;
    logic signed [35:0] tare_off;
    logic [31:0] hold;
    btn_t btn_q;
    logic lin_en;
    logic fail;
    logic last_remove;
    logic [4:0] sel;
    logic [4:0] cnt;
    logic [15:0] dval;
    logic [NPTS-1:0][15:0] cur;
    logic [NPTS-1:0][15:0] dsp;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    disp_t disp;
  } state_t;
endpackage

/* design/tare_code_lineariser_control.sv */
// Tare, access code, restore and lineariser control with AXI4-Lite slave
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module tare_code_lineariser_control
  import lin_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = TARE_HOLD_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Front panel and loop
  input wire btn_t btn,
  input wire logic [15:0] loop_ua,
  // Display drive
  output disp_t disp
);
  state_t s;
  state_t n;
  btn_t press;
  logic wr;
  logic rd;
  logic [4:0] lo;
  logic [4:0] hi;
  logic signed [35:0] dx;
  logic signed [35:0] dd;
  logic signed [35:0] dc;
  logic signed [35:0] gross;
  logic signed [35:0] net;
  logic over;
  logic under;
  logic do_ins;
  logic do_remove;
  logic do_cap;
  logic cap_ok;
  logic [15:0] cprev;
  logic [15:0] cnext;

  assign press = btn & ~s.btn_q;
  assign wr = awvalid && wvalid && !s.bvalid;
  assign rd = arvalid && !s.rvalid;
  assign awready = wr;
  assign wready = wr;
  assign arready = !s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign disp = s.disp;

  // Commands carried by a control write; strobe 1 holds the command bits
  assign do_ins = wr && awaddr == A_CTRL && wstrb[1] && wdata[C_INS]
    && s.lin_en && s.cnt < MAX_PTS;
  assign do_remove = wr && awaddr == A_CTRL && wstrb[1] && wdata[C_REMOVE]
    && s.lin_en && s.cnt > MIN_PTS;
  assign do_cap = wr && awaddr == A_CTRL && wstrb[1] && wdata[C_CAP]
    && s.lin_en;

  always_comb begin
    cprev = (s.sel == 5'h00) ? 16'h0000 : s.cur[s.sel - 5'h01];
    cnext = (s.sel == s.cnt - 5'h01) ? 16'hffff : s.cur[s.sel + 5'h01];
    cap_ok = loop_ua >= CUR_MIN_UA && loop_ua <= CUR_MAX_UA
      && (s.sel == 5'h00 || loop_ua > cprev)
      && (s.sel == s.cnt - 5'h01 || loop_ua < cnext);
  end

  // Segment search: lowest point above the input, else last segment
  always_comb begin
    hi = s.cnt - 5'h01;
    if (s.lin_en) begin
      for (int i = NPTS - 1; i >= 1; i--) begin
        if (5'(i) < s.cnt && loop_ua < s.cur[i]) begin
          hi = 5'(i);
        end
      end
    end
    lo = s.lin_en ? hi - 5'h01 : 5'h00;
    dx = $signed({20'h00000, loop_ua}) - $signed({20'h00000, s.cur[lo]});
    dc = $signed({20'h00000, s.cur[hi]}) - $signed({20'h00000, s.cur[lo]});
    if (dc == 36'sh0) begin
      dc = 36'sh1;
    end
    dd = 36'(signed'(s.dsp[hi])) - 36'(signed'(s.dsp[lo]));
    gross = 36'(signed'(s.dsp[lo])) + (dd * dx) / dc;
    net = s.tare_on ? gross - s.tare_off : gross;
    over = net > DISP_MAX;
    under = net < DISP_MIN;
  end

  always_comb begin
    n = s;
    n.btn_q = btn;
    // Front panel sequencing
    unique case (s.mode)
      ST_DISPLAY: begin
        n.hold = btn.enter ? s.hold + ((s.hold == '1) ? 32'h0 : 32'h1)
          : 32'h0;
        if (btn.enter && s.tare_setting && s.hold == HOLD_CYCLES - 1) begin
          n.tare_on = 1'b1;
          n.tare_off = gross;
        end
        if (!btn.enter && s.btn_q.enter && s.hold < HOLD_CYCLES
            && s.tare_on) begin
          n.tare_on = 1'b0;
        end
        if (press.prog) begin
          n.entry = 16'h0000;
          n.dig = 2'h0;
          n.mode = (s.code == CODE_DEF) ? ST_MENU : ST_CODE;
        end
      end
      ST_CODE: begin
        if (press.up) begin
          n.entry[4*s.dig +: 4] = (s.entry[4*s.dig +: 4] == 4'h9) ? 4'h0
            : s.entry[4*s.dig +: 4] + 4'h1;
        end else if (press.down) begin
          n.entry[4*s.dig +: 4] = (s.entry[4*s.dig +: 4] == 4'h0) ? 4'h9
            : s.entry[4*s.dig +: 4] - 4'h1;
        end else if (press.prog) begin
          n.dig = s.dig + 2'h1;
          if (s.dig == 2'h3) begin
            n.mode = (s.entry == s.code) ? ST_MENU : ST_DISPLAY;
          end
        end else if (press.enter) begin
          n.mode = ST_DISPLAY;
        end
      end
      ST_MENU: begin
        if (press.prog) begin
          n.mode = ST_TARE_ITEM;
        end else if (press.enter) begin
          n.mode = ST_DISPLAY;
          n.code = s.code_pend;
          n.hold = 32'h0;
        end
      end
      ST_TARE_ITEM: begin
        if (press.up || press.down) begin
          n.tare_setting = !s.tare_setting;
        end else if (press.enter) begin
          n.mode = ST_MENU;
        end
      end
    endcase

    // Register writes; both channels are taken together
    if (wr) begin
      n.bvalid = 1'b1;
      n.bresp = 2'b00;
      unique case (awaddr)
        A_CTRL: begin
          if (wstrb[0]) begin
            n.lin_en = wdata[C_LIN];
          end
          if (wstrb[1] && wdata[C_CAL]) begin
            n.sel = 5'h00;
          end
          if (wstrb[1] && wdata[C_CLRF]) begin
            n.fail = 1'b0;
          end
          if (wstrb[1] && wdata[C_RTAB]) begin
            n.cnt = MIN_PTS;
            n.sel = 5'h00;
            n.cur[0] = DEF_C0;
            n.cur[1] = DEF_C1;
            n.dsp[0] = DEF_D0;
            n.dsp[1] = DEF_D1;
          end else if (wstrb[1] && wdata[C_RCONF]) begin
            n.lin_en = 1'b0;
            n.tare_setting = 1'b0;
            n.tare_on = 1'b0;
            n.code_pend = CODE_DEF;
          end else if (do_ins) begin
            for (int i = 1; i < NPTS; i++) begin
              if (5'(i) > s.sel && 5'(i) <= s.cnt) begin
                n.cur[i] = s.cur[i-1];
                n.dsp[i] = s.dsp[i-1];
              end
            end
            n.cnt = s.cnt + 5'h01;
            n.last_remove = 1'b0;
          end else if (do_remove) begin
            for (int i = 0; i < NPTS - 1; i++) begin
              if (5'(i) >= s.sel && 5'(i) < s.cnt - 5'h01) begin
                n.cur[i] = s.cur[i+1];
                n.dsp[i] = s.dsp[i+1];
              end
            end
            n.cnt = s.cnt - 5'h01;
            if (s.sel >= s.cnt - 5'h01) begin
              n.sel = s.cnt - 5'h02;
            end
            n.last_remove = 1'b1;
          end else if (do_cap) begin
            if (cap_ok) begin
              n.cur[s.sel] = loop_ua;
              n.dsp[s.sel] = s.dval;
            end else begin
              n.fail = 1'b1;
            end
          end
        end
        A_SEL: begin
          if (wstrb[0]) begin
            n.sel = (wdata[4:0] < s.cnt) ? wdata[4:0] : s.cnt - 5'h01;
          end
        end
        A_DVAL: begin
          n.dval[7:0] = wstrb[0] ? wdata[7:0] : s.dval[7:0];
          n.dval[15:8] = wstrb[1] ? wdata[15:8] : s.dval[15:8];
        end
        A_CODE: begin
          n.code_pend[7:0] = wstrb[0] ? wdata[7:0] : s.code_pend[7:0];
          n.code_pend[15:8] = wstrb[1] ? wdata[15:8] : s.code_pend[15:8];
        end
        A_STAT, A_DISP: begin
        end
        default: begin
          n.bresp = 2'b10;
        end
      endcase
    end else if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    // Register reads
    if (rd) begin
      n.rvalid = 1'b1;
      n.rresp = 2'b00;
      n.rdata = 32'h0;
      unique case (araddr)
        A_CTRL: n.rdata[C_LIN] = s.lin_en;
        A_SEL: n.rdata[4:0] = s.sel;
        A_DVAL: n.rdata[15:0] = s.dval;
        A_CODE: n.rdata[15:0] = s.code_pend;
        A_STAT: begin
          n.rdata[S_FAIL] = s.fail;
          n.rdata[S_TARE] = s.tare_on;
          n.rdata[S_TEN] = s.tare_setting;
          n.rdata[S_LDEL] = s.last_remove;
          n.rdata[S_MODE +: 2] = s.mode;
          n.rdata[S_SEL +: 5] = s.sel;
          n.rdata[S_CNT +: 5] = s.cnt;
        end
        A_DISP: n.rdata = {s.disp.bar, s.disp.value};
        default: n.rresp = 2'b10;
      endcase
    end else if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Display and bargraph drive
    n.disp.value = over ? DISP_MAX[15:0] : under ? DISP_MIN[15:0]
      : net[15:0];
    n.disp.dp_flash = over || under;
    n.disp.bar = over ? DISP_MAX[15:0] : under ? DISP_MIN[15:0]
      : net[15:0];
    n.disp.tare_ann = n.tare_on;
    n.disp.low_loop_warning = loop_ua < LOW_LOOP_UA;
    n.disp.arrow_lo = net < BAR_LO;
    n.disp.arrow_hi = net > BAR_HI;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.cnt <= MIN_PTS;
      s.cur[0] <= DEF_C0;
      s.cur[1] <= DEF_C1;
      s.dsp[0] <= DEF_D0;
      s.dsp[1] <= DEF_D1;
      s.code <= CODE_DEF;
      s.code_pend <= CODE_DEF;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  tare_set_a: assert property (
    s.mode == ST_DISPLAY && btn.enter && s.tare_setting
      && s.hold == HOLD_CYCLES - 1
    |=> s.tare_on && s.tare_off == $past(gross) ##1 s.disp.tare_ann)
    else $error("tare not applied after long enter press");
  tare_clear_a: assert property (
    s.mode == ST_DISPLAY && !btn.enter && s.btn_q.enter
      && s.hold < HOLD_CYCLES && s.tare_on
    |=> !s.tare_on)
    else $error("tare not released by short press");
  bar_follow_a: assert property (
    s.tare_on && !over && !under |=> s.disp.bar == $past(net[15:0]))
    else $error("bargraph not following tared value");
  tare_toggle_a: assert property (
    s.mode == ST_TARE_ITEM && (press.up || press.down)
    |=> s.tare_setting != $past(s.tare_setting))
    else $error("tare setting not inverted");
  code_gate_a: assert property (
    s.mode == ST_DISPLAY && press.prog && s.code != CODE_DEF
    |=> s.mode == ST_CODE)
    else $error("menu entered without code");
  code_free_a: assert property (
    s.mode == ST_DISPLAY && press.prog && s.code == CODE_DEF
    |=> s.mode == ST_MENU)
    else $error("default code did not grant access");
  code_late_a: assert property (
    s.code != $past(s.code)
    |-> $past(s.mode) == ST_MENU && s.mode == ST_DISPLAY)
    else $error("code changed outside menu exit");
  range_nines_a: assert property (
    over |=> s.disp.value == DISP_MAX[15:0] && s.disp.dp_flash)
    else $error("overrange pattern missing");
  low_loop_a: assert property (
    loop_ua < LOW_LOOP_UA |=> s.disp.low_loop_warning)
    else $error("low loop warning missing");
  cap_fail_a: assert property (
    do_cap && !cap_ok && !wdata[C_RTAB] && !wdata[C_RCONF]
      && !wdata[C_INS] && !wdata[C_REMOVE]
    |=> s.fail && s.cur == $past(s.cur))
    else $error("bad capture not rejected");
  min_pts_a: assert property (
    s.cnt >= MIN_PTS && s.cnt <= MAX_PTS)
    else $error("point count out of bounds");
  ins_cnt_a: assert property (
    do_ins && !wdata[C_RTAB] && !wdata[C_RCONF]
    |=> s.cnt == $past(s.cnt) + 5'h01 && !s.last_remove)
    else $error("insert did not grow table");

  tare_cov_c: cover property ($rose(s.tare_on));
  code_cov_c: cover property (s.mode == ST_CODE ##[1:60] s.mode == ST_MENU);
  remove_cov_c: cover property (do_remove ##1 s.cnt == MIN_PTS);
  fail_cov_c: cover property ($rose(s.fail));
endmodule

/* verif/panel_model.sv */
// Front-panel button and loop current source model
`timescale 1ns/100ps
module panel_model
  import lin_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Towards the block
  output btn_t btn,
  output logic [15:0] loop_ua
);
  initial begin
    btn = '0;
    loop_ua = 16'h2ee0;
  end

  // Holds one button, then leaves it released long enough to settle
  task automatic press(input int b, input int cyc);
    @(posedge aclk);
    btn[b] <= 1'b1;
    repeat (cyc) @(posedge aclk);
    btn[b] <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // Operator sets the true loop current before any capture
  task automatic set_loop(input logic [15:0] ua);
    @(posedge aclk);
    loop_ua <= ua;
    repeat (4) @(posedge aclk);
  endtask
endmodule

/* verif/tare_code_lineariser_control_test.sv */
// Self-checking bench for the tare, code and lineariser control
`timescale 1ns/100ps
module tare_code_lineariser_control_test;
  import lin_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h3;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr, rb;
  logic [31:0] rdata, r;
  btn_t btn;
  logic [15:0] loop_ua;
  disp_t disp;
  int mismatches = 0;
  int checked = 0;

  always #4 aclk = ~aclk;

  tare_code_lineariser_control #(.HOLD_CYCLES(20))
    tare_code_lineariser_control_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .btn(btn),
    .loop_ua(loop_ua), .disp(disp));

  panel_model panel_model_i (.aclk(aclk), .btn(btn), .loop_ua(loop_ua));

  task automatic chk(input string n, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    rb = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    r = rdata;
    rr = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic pr(input int b, input int c = 1);
    panel_model_i.press(b, c);
  endtask

  task automatic lp(input logic [15:0] ua);
    panel_model_i.set_loop(ua);
  endtask

  task automatic md(input logic [1:0] e);
    rd(A_STAT);
    chk("mode", r[5:4], e);
  endtask

  // Display value settles a few edges after its cause
  task automatic val(input logic [15:0] e);
    repeat (3) @(negedge aclk);
    chk("value", {16'h0000, disp.value}, {16'h0000, e});
  endtask

  task automatic dv(input logic [31:0] e);
    rd(A_DISP);
    chk("disp_reg", r, e);
    @(negedge aclk);
    chk("disp_port", {disp.bar, disp.value}, e);
  endtask

  task automatic t_reset;
    rd(A_CTRL);
    chk("ctrl", r, 32'h0000_0000);
    rd(A_STAT);
    chk("stat", r, 32'h0002_0000);
    rd(A_CODE);
    chk("code", r, 32'h0000_0000);
    rd(8'h18);
    chk("resp", rr, 2'h2);
    chk("unmapped", r, 32'h0000_0000);
    wr(8'h18, 32'h0000_0001);
    chk("wresp_unmapped", rb, 2'h2);
  endtask

  task automatic t_menu;
    wr(A_CODE, 32'h0000_0001);
    chk("wresp", rb, 2'h0);
    pr(0);
    md(2'h2);
    pr(0);
    md(2'h3);
    pr(2);
    rd(A_STAT);
    chk("tare_en", r[2], 1'b1);
    pr(1);
    rd(A_STAT);
    chk("tare_en", r[2], 1'b0);
    pr(2);
    pr(3);
    md(2'h2);
    pr(3);
    pr(0);
    md(2'h1);
    pr(2);
    repeat (4) pr(0);
    md(2'h2);
    pr(3);
    pr(0);
    repeat (4) pr(0);
    md(2'h0);
    pr(0);
    md(2'h1);
    pr(1);
    pr(3);
    md(2'h0);
  endtask

  task automatic t_tare;
    lp(16'h2ee0);
    dv(32'h01f4_01f4);
    pr(3, 25);
    dv(32'h0000_0000);
    chk("tare_ann", disp.tare_ann, 1'b1);
    lp(16'h32c8);
    dv(32'h003e_003e);
    pr(3, 3);
    dv(32'h0232_0232);
    chk("tare_ann", disp.tare_ann, 1'b0);
  endtask

  task automatic t_range;
    wr(A_CTRL, 32'h0000_0001);
    wr(A_SEL, 32'h0000_0001);
    wr(A_DVAL, 32'h0000_2328);
    lp(16'h1388);
    wr(A_CTRL, 32'h0000_0401);
    lp(16'h13ec);
    val(16'h26ac);
    lp(16'h0f3c);
    val(16'hfc7c);
    chk("arrow_lo", disp.arrow_lo, 1'b1);
    lp(16'h4e20);
    val(16'h270f);
    chk("dp_flash", disp.dp_flash, 1'b1);
    chk("arrow_hi", disp.arrow_hi, 1'b1);
    lp(16'h0bb8);
    val(16'hfc19);
    lp(16'h06a4);
    @(negedge aclk);
    chk("low_loop", disp.low_loop_warning, 1'b1);
    lp(16'h0fa0);
    wr(A_CTRL, 32'h0000_0401);
    rd(A_STAT);
    chk("fail", r[0], 1'b1);
    lp(16'h13ec);
    val(16'h26ac);
  endtask

  task automatic t_edit;
    wr(A_CTRL, 32'h0000_4001);
    wr(A_CTRL, 32'h0000_0101);
    rd(A_STAT);
    chk("fail", r[0], 1'b0);
    chk("count", r[20:16], 5'h03);
    chk("last_remove", r[3], 1'b0);
    wr(A_SEL, 32'h0000_0001);
    wr(A_DVAL, 32'h0000_03e8);
    lp(16'h1194);
    wr(A_CTRL, 32'h0000_0401);
    lp(16'h109a);
    val(16'h01f4);
    lp(16'h128e);
    val(16'h1388);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0100);
    val(16'h1a5e);
    wr(A_CTRL, 32'h0000_0001);
    val(16'h1388);
    rd(A_STAT);
    chk("count", r[20:16], 5'h03);
    wr(A_SEL, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_0201);
    rd(A_STAT);
    chk("count", r[20:16], 5'h02);
    chk("last_remove", r[3], 1'b1);
    val(16'h1a5e);
    wr(A_CTRL, 32'h0000_0201);
    wr(A_CTRL, 32'h0000_2001);
    rd(A_STAT);
    chk("count", r[20:16], 5'h02);
    chk("sel", r[12:8], 5'h00);
  endtask

  task automatic t_restore;
    wr(A_CTRL, 32'h0000_0101);
    wr(A_CTRL, 32'h0000_1001);
    rd(A_STAT);
    chk("count", r[20:16], 5'h02);
    chk("tare_en", r[2], 1'b1);
    rd(A_CTRL);
    chk("lin_en", r[0], 1'b1);
    lp(16'h2ee0);
    val(16'h01f4);
    wr(A_CTRL, 32'h0000_0800);
    rd(A_CTRL);
    chk("lin_en", r[0], 1'b0);
    rd(A_STAT);
    chk("tare_en", r[2], 1'b0);
  endtask

  task automatic report_and_stop;
    $display("Counts: %0d mismatches, %0d checked", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_menu;
    t_tare;
    t_range;
    t_edit;
    t_restore;
    report_and_stop;
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    report_and_stop;
  end
endmodule
